// ### hw/uls_top.sv
// UART receiver, transmitter and line status register behind an APB slave.
// Assumes serial_rx_input is asynchronous and is synchronised here.
// Notes on behaviour
// - Error summary reads zero without FIFO; set while errored entries sit in FIFO.
// - Error summary clears once no errored entries remain; a status read does not clear it.
// - Transmitter empty only when holding store and shift register are both empty.
// - Without FIFO, holding empty sets on move to shifter, clears on load.
// - With FIFO, holding empty follows transmit FIFO empty.
// - Holding going empty, with its enable, raises the interrupt.
// - Break sets when input stays low from the start bit through the stop bit sample.
// - Break loads one zero character, then waits for mark and a start bit.
// - FIFO mode: errors travel with their character, shown at the head.
// - Bits one to four raise the line status interrupt when enabled.
// - Framing error sets when the stop bit samples low.
// - After framing error without break the low level is taken as the next start bit.
// - Parity error sets on a failed even or odd check.
// - Without FIFO, overrun sets when a character overwrites an unread one.
// - FIFO mode: overrun when full and another arrives; that character is dropped.
// - Data ready sets on store and clears once all receive data is read.
// - Reading the status register clears break, framing, parity and overrun.
`timescale 1ns/1ns
module uls_top
   import uls_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial line.
   input  wire logic        serial_rx_input,
   output logic             serial_tx_output,
   // Interrupt.
   output logic             irq
);
   typedef struct packed {
      logic [1:0]                         sync;
      logic [3:0]                         ctrl;
      logic [15:0]                        div;
      logic [15:0]                        baud_cnt;
      uls_rx_t                            rx_st;
      logic [3:0]                         rx_ovs;
      logic [3:0]                         rx_bit;
      logic [8:0]                         rx_sh;
      logic [7:0]                         brk_cnt;
      logic [FIFO_DEPTH-1:0][FIFO_W-1:0]  rx_mem;
      logic [FIFO_AW-1:0]                 rx_rd;
      logic [FIFO_AW-1:0]                 rx_wr;
      logic [FIFO_AW:0]                   rx_cnt;
      logic                               oe, pe, fe, bi;
      logic [FIFO_DEPTH-1:0][7:0]         tx_mem;
      logic [FIFO_AW-1:0]                 tx_rd;
      logic [FIFO_AW-1:0]                 tx_wr;
      logic [FIFO_AW:0]                   tx_cnt;
      uls_tx_t                            tx_st;
      logic [3:0]                         tx_ovs;
      logic [3:0]                         tx_bit;
      logic [8:0]                         tx_sh;
      logic                               txo;
      logic [2:0]                         irq_stat;
      logic [2:0]                         irq_en;
      logic [31:0]                        rdata;
   } uls_state_t;

   uls_state_t st_ff;
   uls_state_t nxt_st;

   // Frame length in bits: start, data, optional parity and one or two stop bits.
   function automatic logic [3:0] frame_bits(input logic [3:0] c);
      frame_bits = 4'(1 + DATA_BITS + (c[CTRL_PAR_EN] ? 1 : 0) + (c[CTRL_STOP2] ? 2 : 1));
   endfunction : frame_bits

   logic       fifo_mode;
   logic [7:0] line_stat;
   logic       err_in_fifo;
   logic       rd_stat, rd_data, wr_tx;
   logic       rx_tick, tx_tick;
   logic       rxd;
   logic [4:0] cap;

   assign fifo_mode = st_ff.ctrl[CTRL_FIFO_EN];
   assign cap       = fifo_mode ? 5'(FIFO_DEPTH) : 5'h01;
   assign rxd       = st_ff.sync[1];
   // A divisor of zero gives a tick on every clock; each bit spans sixteen ticks.
   assign rx_tick   = (st_ff.baud_cnt == 16'h0000);
   // Both directions share one baud tick, which keeps a single divisor register.
   assign tx_tick   = rx_tick;

   // Every occupied entry is scanned, so the summary follows the whole store.
   // The cost is a wide OR over all entries, which the small depth makes acceptable.
   always_comb begin
      err_in_fifo = 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         if (5'(i) < st_ff.rx_cnt &&
             st_ff.rx_mem[4'(st_ff.rx_rd + 4'(i))][10:8] != 3'h0) begin
            err_in_fifo = 1'b1;
         end
      end
   end

   always_comb begin
      line_stat          = 8'h00;
      line_stat[LS_DR]   = (st_ff.rx_cnt != 5'h00);
      line_stat[LS_OE]   = st_ff.oe;
      line_stat[LS_PE]   = st_ff.pe;
      line_stat[LS_FE]   = st_ff.fe;
      line_stat[LS_BI]   = st_ff.bi;
      line_stat[LS_HOLDING_REG_EMPTY] = (st_ff.tx_cnt == 5'h00);
      line_stat[LS_TRANSMITTER_EMPTY] = (st_ff.tx_cnt == 5'h00) && (st_ff.tx_st == TX_IDLE);
      line_stat[LS_FERR] = fifo_mode && err_in_fifo;
   end

   assign rd_stat = psel && penable && !pwrite && paddr == ADDR_LINE_STAT;
   assign rd_data = psel && penable && !pwrite && paddr == ADDR_RX_DATA;
   // A write to a full transmit store is dropped; software polls holding empty first.
   assign wr_tx   = psel && penable && pwrite && paddr == ADDR_TX_DATA &&
                    st_ff.tx_cnt < cap;

   always_comb begin
      logic       push;
      logic [2:0] err;
      logic [2:0] ev;
      logic       par;
      logic       pop;
      logic       tx_pop;
      logic [7:0] rx_byte;
      push   = 1'b0;
      rx_byte = 8'h00;
      err    = 3'h0;
      ev     = 3'h0;
      par    = 1'b0;
      // A read of an empty receive store returns stale data and moves nothing.
      pop    = rd_data && st_ff.rx_cnt != 5'h00;
      tx_pop = 1'b0;
      nxt_st = st_ff;
      // Two flip-flops bring the asynchronous receive pin into the clock domain.
      nxt_st.sync = {st_ff.sync[0], serial_rx_input};
      nxt_st.baud_cnt = rx_tick ? st_ff.div : st_ff.baud_cnt - 16'h0001;

      // Receiver, sampled at sixteen times the bit rate.
      if (rx_tick) begin
         nxt_st.rx_ovs = st_ff.rx_ovs + 4'h1;
         case (st_ff.rx_st)
            RX_IDLE: begin
               // The start bit is confirmed at mid-bit, which rejects short glitches.
               nxt_st.rx_ovs = 4'h0;
               if (!rxd) begin
                  nxt_st.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (st_ff.rx_ovs == OVS_MID) begin
                  nxt_st.rx_ovs = 4'h0;
                  nxt_st.rx_bit = 4'h0;
                  nxt_st.brk_cnt = 8'h01;
                  // Start from zero so that a break is seen with or without parity.
                  nxt_st.rx_sh = 9'h000;
                  nxt_st.rx_st = rxd ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS: begin
               if (st_ff.rx_ovs == OVS_END) begin
                  nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                  nxt_st.brk_cnt = rxd ? 8'h00 : st_ff.brk_cnt + 8'h01;
                  if (st_ff.rx_bit < 4'(DATA_BITS) + (st_ff.ctrl[CTRL_PAR_EN] ? 4'h1 : 4'h0)) begin
                     nxt_st.rx_sh = {rxd, st_ff.rx_sh[8:1]};
                  end else begin
                     push = 1'b1;
                     // With parity the ninth shift moves the data one place down.
                     rx_byte = st_ff.ctrl[CTRL_PAR_EN] ? st_ff.rx_sh[7:0] : st_ff.rx_sh[8:1];
                     par = ^st_ff.rx_sh[8:1] ^ st_ff.rx_sh[0];
                     if (!st_ff.ctrl[CTRL_PAR_EN]) begin
                        par = 1'b0;
                     end else if (!st_ff.ctrl[CTRL_PAR_EVEN]) begin
                        par = !par;
                     end
                     err[2] = (st_ff.rx_sh[0] == 1'b0) && !rxd && st_ff.brk_cnt != 8'h00 &&
                              st_ff.rx_sh == 9'h000;
                     err[1] = !rxd;
                     err[0] = par;
                     if (err[2]) begin
                        nxt_st.rx_st = RX_BRK;
                     end else if (!rxd) begin
                        nxt_st.rx_ovs = OVS_MID - 4'h1;
                        nxt_st.rx_st = RX_START;
                     end else begin
                        nxt_st.rx_st = RX_IDLE;
                     end
                  end
               end
            end
            RX_BRK: begin
               // After a break the line is ignored until it returns to mark.
               nxt_st.rx_ovs = 4'h0;
               if (rxd) begin
                  nxt_st.rx_st = RX_IDLE;
               end
            end
            default: nxt_st.rx_st = RX_IDLE;
         endcase
      end

      if (st_ff.ctrl[CTRL_PAR_EN] == 1'b0) begin
         par = 1'b0;
      end

      // Break needs the whole frame low: data and parity all zero plus a low stop bit.
      if (push && err[2]) begin
         err[1] = 1'b1;
      end

      // Only flags shown in the captured read value are cleared, so an error that
      // lands between the setup and access edges survives until the next read.
      if (rd_stat) begin
         nxt_st.oe = st_ff.oe & ~st_ff.rdata[LS_OE];
         nxt_st.pe = st_ff.pe & ~st_ff.rdata[LS_PE];
         nxt_st.fe = st_ff.fe & ~st_ff.rdata[LS_FE];
         nxt_st.bi = st_ff.bi & ~st_ff.rdata[LS_BI];
      end

      if (pop) begin
         nxt_st.rx_rd = st_ff.rx_rd + 4'h1;
         nxt_st.rx_cnt = st_ff.rx_cnt - 5'h01;
      end

      // Without FIFO the newest character replaces the unread one; with FIFO it is dropped.
      if (push) begin
         if (st_ff.rx_cnt - (pop ? 5'h01 : 5'h00) >= cap) begin
            if (fifo_mode) begin
               nxt_st.oe = 1'b1;
            end else begin
               nxt_st.oe = 1'b1;
               nxt_st.rx_mem[st_ff.rx_rd] = {err, rx_byte};
            end
         end else begin
            nxt_st.rx_mem[st_ff.rx_wr] =
               {err, err[2] ? 8'h00 : rx_byte};
            nxt_st.rx_wr = st_ff.rx_wr + 4'h1;
            nxt_st.rx_cnt = nxt_st.rx_cnt + 5'h01;
         end
         if (!fifo_mode) begin
            nxt_st.bi = nxt_st.bi | err[2];
            nxt_st.fe = nxt_st.fe | err[1];
            nxt_st.pe = nxt_st.pe | err[0];
         end
      end

      // FIFO mode shows the errors of the head entry only.
      if (fifo_mode && nxt_st.rx_cnt != 5'h00 &&
          (pop || (push && st_ff.rx_cnt == 5'h00))) begin
         nxt_st.bi = nxt_st.bi | nxt_st.rx_mem[nxt_st.rx_rd][10];
         nxt_st.fe = nxt_st.fe | nxt_st.rx_mem[nxt_st.rx_rd][9];
         nxt_st.pe = nxt_st.pe | nxt_st.rx_mem[nxt_st.rx_rd][8];
      end

      // Transmitter.
      // The holding store empties on the idle tick, as the shifter takes the character.
      if (tx_tick) begin
         nxt_st.tx_ovs = st_ff.tx_ovs + 4'h1;
         case (st_ff.tx_st)
            TX_IDLE: begin
               nxt_st.txo = 1'b1;
               nxt_st.tx_ovs = 4'h0;
               if (st_ff.tx_cnt != 5'h00) begin
                  tx_pop = 1'b1;
                  nxt_st.tx_sh = {^st_ff.tx_mem[st_ff.tx_rd] ^ !st_ff.ctrl[CTRL_PAR_EVEN],
                                  st_ff.tx_mem[st_ff.tx_rd]};
                  nxt_st.tx_bit = 4'h0;
                  nxt_st.txo = 1'b0;
                  nxt_st.tx_st = TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (st_ff.tx_ovs == OVS_END) begin
                  nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                  if (st_ff.tx_bit < 4'(DATA_BITS) + (st_ff.ctrl[CTRL_PAR_EN] ? 4'h1 : 4'h0)) begin
                     nxt_st.txo = st_ff.tx_sh[0];
                     nxt_st.tx_sh = {1'b1, st_ff.tx_sh[8:1]};
                  end else begin
                     nxt_st.txo = 1'b1;
                     nxt_st.tx_st = TX_STOP;
                  end
               end
            end
            TX_STOP: begin
               if (st_ff.tx_ovs == OVS_END) begin
                  nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                  if (st_ff.tx_bit + 4'h1 >= frame_bits(st_ff.ctrl)) begin
                     nxt_st.tx_st = TX_IDLE;
                  end
               end
            end
            default: nxt_st.tx_st = TX_IDLE;
         endcase
      end
      if (tx_pop) begin
         nxt_st.tx_rd = st_ff.tx_rd + 4'h1;
      end
      if (wr_tx) begin
         nxt_st.tx_mem[st_ff.tx_wr] = pwdata[7:0];
         nxt_st.tx_wr = st_ff.tx_wr + 4'h1;
      end
      nxt_st.tx_cnt = st_ff.tx_cnt + (wr_tx ? 5'h01 : 5'h00) - (tx_pop ? 5'h01 : 5'h00);

      // Interrupts: set wins over clear.
      // Line status fires when the error flags go from none to some, not on their level.
      ev[IRQ_RLS]  = (nxt_st.oe | nxt_st.pe | nxt_st.fe | nxt_st.bi) &
                     !(st_ff.oe | st_ff.pe | st_ff.fe | st_ff.bi);
      ev[IRQ_HOLDING_REG_EMPTY] = tx_pop && st_ff.tx_cnt == 5'h01 && !wr_tx;
      ev[IRQ_RDA]  = push;
      if (psel && penable && pwrite && paddr == ADDR_IRQ_CLR) begin
         nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[2:0];
      end
      nxt_st.irq_stat = nxt_st.irq_stat | ev;

      if (psel && penable && pwrite) begin
         case (paddr)
            ADDR_CTRL: begin
               nxt_st.ctrl = pwdata[3:0];
               nxt_st.div  = pwdata[31:16];
            end
            ADDR_IRQ_EN: nxt_st.irq_en = pwdata[2:0];
            default: ;
         endcase
      end

      // Read data is taken at every edge from the address; unmapped offsets read zero.
      nxt_st.rdata = 32'h0000_0000;
      case (paddr)
         ADDR_RX_DATA:   nxt_st.rdata = {24'h000000, st_ff.rx_mem[st_ff.rx_rd][7:0]};
         ADDR_CTRL:      nxt_st.rdata = {st_ff.div, 12'h000, st_ff.ctrl};
         ADDR_LINE_STAT: nxt_st.rdata = {24'h000000, line_stat};
         ADDR_IRQ_STAT:  nxt_st.rdata = {29'h0, st_ff.irq_stat};
         ADDR_IRQ_EN:    nxt_st.rdata = {29'h0, st_ff.irq_en};
         default:        nxt_st.rdata = 32'h0000_0000;
      endcase

      // Reset comes last so that it overrides every update above.
      if (srst) begin
         nxt_st = '0;
         nxt_st.sync = 2'h3;
         nxt_st.ctrl = CTRL_RESET;
         nxt_st.div = CTRL_DIV_RESET;
         nxt_st.rx_st = RX_IDLE;
         nxt_st.tx_st = TX_IDLE;
         nxt_st.txo = 1'b1;
         nxt_st.irq_stat = IRQ_RESET;
         nxt_st.irq_en = IRQ_RESET;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   // Read data is captured in the setup cycle so the access phase needs no wait.
   // With no wait states there is nothing to refuse, so the error response stays low.
   assign prdata           = st_ff.rdata;
   assign pready           = 1'b1;
   assign pslverr          = 1'b0;
   assign serial_tx_output = st_ff.txo;
   // A level output: it stays high until software clears the status bit or its enable.
   assign irq              = |(st_ff.irq_stat & st_ff.irq_en);
endmodule : uls_top

// ### include/uls_pkg.sv
// Constants for the UART line status block.
// Assumes an APB slave with 32-bit data and byte addresses.
package uls_pkg;
   localparam logic [7:0] ADDR_RX_DATA    = 8'h00;
   localparam logic [7:0] ADDR_TX_DATA    = 8'h04;
   localparam logic [7:0] ADDR_CTRL       = 8'h08;
   localparam logic [7:0] ADDR_LINE_STAT  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLR    = 8'h24;
   localparam logic [7:0] ADDR_IRQ_EN     = 8'h28;
   // Control register field positions.
   localparam int CTRL_FIFO_EN  = 0;
   localparam int CTRL_PAR_EN   = 1;
   localparam int CTRL_PAR_EVEN = 2;
   localparam int CTRL_STOP2    = 3;
   localparam logic [15:0] CTRL_DIV_RESET = 16'h0010;
   localparam logic [3:0]  CTRL_RESET     = 4'h0;
   // Line status bit positions.
   localparam int LS_DR = 0;
   localparam int LS_OE = 1;
   localparam int LS_PE = 2;
   localparam int LS_FE = 3;
   localparam int LS_BI = 4;
   localparam int LS_HOLDING_REG_EMPTY = 5;
   localparam int LS_TRANSMITTER_EMPTY = 6;
   localparam int LS_FERR = 7;
   // Interrupt status bits.
   localparam int IRQ_RLS  = 0;
   localparam int IRQ_HOLDING_REG_EMPTY = 1;
   localparam int IRQ_RDA  = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW    = 4;
   localparam int FIFO_W     = 11;
   localparam int DATA_BITS  = 8;
   localparam int OVS        = 16;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] OVS_END = 4'hf;
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS  = 4'b0100,
      RX_BRK   = 4'b1000
   } uls_rx_t;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_SHIFT = 3'b010,
      TX_STOP  = 3'b100
   } uls_tx_t;
endpackage : uls_pkg

// ### tb/uls_top_chk.sv
// Checker for the line status block, bound to the top module's ports.
// Assumes an APB master that keeps setup and access phases apart.
`timescale 1ns/1ns
module uls_top_chk
   import uls_pkg::*;
(
   // Clock and reset.
   input wire logic        clk,
   input wire logic        srst,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial line and interrupt.
   input wire logic        serial_rx_input,
   input wire logic        serial_tx_output,
   input wire logic        irq
);
   logic       fifo_ff;
   logic [2:0] en_ff;
   logic       acc;
   logic       lsr_rd;
   assign acc    = psel && penable;
   assign lsr_rd = acc && !pwrite && paddr == ADDR_LINE_STAT;
   // The mode and enable are shadowed from the bus, since the inside is hidden.
   always_ff @(posedge clk) begin
      if (srst) begin
         fifo_ff <= 1'b0;
         en_ff   <= 3'h0;
      end else if (acc && pwrite) begin
         if (paddr == ADDR_CTRL) fifo_ff <= pwdata[CTRL_FIFO_EN];
         if (paddr == ADDR_IRQ_EN) en_ff <= pwdata[2:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   zero_wait_a: assert property (acc |-> pready && !pslverr)
      else $error("Access phase not completed cleanly");
   reset_quiet_a: assert property (disable iff (1'b0) srst |=> !irq && serial_tx_output)
      else $error("Outputs not quiet after reset");
   unmapped_zero_a: assert property (acc && !pwrite && paddr == 8'h30 |-> prdata == 32'h0)
      else $error("Unmapped read not zero");
   summary_off_a: assert property (lsr_rd && !fifo_ff |-> !prdata[LS_FERR])
      else $error("Error summary set without FIFO");
   transmitter_empty_holding_reg_empty_a: assert property (lsr_rd && prdata[LS_TRANSMITTER_EMPTY] |-> prdata[LS_HOLDING_REG_EMPTY])
      else $error("Transmitter empty while holding store full");
   head_summary_a: assert property (lsr_rd && fifo_ff && |prdata[4:2] |-> prdata[LS_FERR])
      else $error("Head error shown without summary");
   irq_masked_a: assert property (en_ff == 3'h0 && $past(en_ff) == 3'h0 |-> !irq)
      else $error("Interrupt raised while all sources masked");
   upper_zero_a: assert property (lsr_rd |-> prdata[31:8] == 24'h0)
      else $error("Status read has upper bits set");
endmodule : uls_top_chk

// ### tb/uls_remote.sv
// Remote serial device driving frames, faulty frames and breaks onto the line.
// Assumes the bench calls its tasks just after a clock edge; one bit is BITC clocks.
`timescale 1ns/1ns
module uls_remote #(
   parameter int BITC = 16
) (
   // Clock.
   input wire logic clk,
   // Line toward the device, at mark when idle.
   output logic     line
);
   initial line = 1'b1;
   task automatic hold(input logic v, input int bits);
      line <= v;
      repeat (bits * BITC) @(posedge clk);
   endtask : hold
   // Even parity; the fault inputs flip parity or pull the stop bit low.
   task automatic send(input logic [7:0] d, input logic fp, input logic lstop);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) begin
         hold(d[i], 1);
      end
      hold((^d) ^ fp, 1);
      hold(!lstop, 1);
      line <= 1'b1;
   endtask : send
endmodule : uls_remote

// ### tb/test_uls_line_status.sv
// Self-checking bench for the line status block with a remote device on its receive line.
// Assumes zero-wait APB and 16 clocks per bit at divisor zero.
`timescale 1ns/1ns
module test_uls_line_status
   import uls_pkg::*;
;
   logic        clk, srst, psel, penable, pwrite, rx_line, tx_line, irq, pready, pslverr;
   logic [7:0]  paddr, d, e, f;
   logic [7:0]  buf_q[16];
   logic [31:0] pwdata, prdata, q;
   int          n_errors, checked;
   int          cyc = 0;
   uls_top uls_top_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_rx_input(rx_line), .serial_tx_output(tx_line), .irq(irq));
   uls_remote uls_remote_inst (.clk(clk), .line(rx_line));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [7:0] errs(input logic pe, input logic fe, input logic bi);
      return {3'h0, bi, fe, pe, 2'h0};
   endfunction : errs
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) n_errors++;
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // The status is read once and kept, because the read clears the error bits.
   task automatic ls(input string nm, input logic [7:0] m, input logic [7:0] ex);
      apb(1'b0, ADDR_LINE_STAT, 32'h0);
      chk(nm, {24'h0, q[7:0] & m}, {24'h0, ex});
   endtask : ls
   task automatic rx(input logic [7:0] v, input logic fp, input logic lstop);
      @(posedge clk);
      uls_remote_inst.send(v, fp, lstop);
      repeat (24) @(posedge clk);
   endtask : rx
   task automatic brk();
      @(posedge clk);
      uls_remote_inst.hold(1'b0, 13);
      uls_remote_inst.hold(1'b1, 2);
      repeat (24) @(posedge clk);
   endtask : brk
   initial begin
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 8'h00;
      pwdata   = 32'h0;
      srst     = 1'b1;
      n_errors = 0;
      checked  = 0;
      void'($urandom(32'h900924f7));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h6);
      apb(1'b1, ADDR_IRQ_EN, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped", q, 32'h0);
      d = 8'($urandom);
      rx(d, 1'b0, 1'b0);
      ls("clean", 8'h1f, 8'h01);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("rx byte", q[7:0], d);
      ls("drained", 8'h01, 8'h00);
      rx(8'($urandom), 1'b1, 1'b0);
      chk("rls irq", irq, 1'b1);
      ls("parity", 8'h1e, errs(1'b1, 1'b0, 1'b0));
      ls("cleared", 8'h1e, 8'h00);
      apb(1'b1, ADDR_IRQ_CLR, 32'h7);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("irq clr", irq, 1'b0);
      rx(8'($urandom), 1'b0, 1'b1);
      repeat (200) @(posedge clk);
      ls("framing", 8'h08, errs(1'b0, 1'b1, 1'b0));
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("resync", q[7:0], 8'hff);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      d = 8'($urandom);
      e = 8'($urandom);
      rx(d, 1'b0, 1'b0);
      rx(e, 1'b0, 1'b0);
      ls("overrun", 8'h03, 8'h03);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("newest kept", q[7:0], e);
      brk();
      ls("break", 8'h10, errs(1'b0, 1'b0, 1'b1));
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h7);
      brk();
      rx(d, 1'b0, 1'b0);
      ls("fifo break", 8'h90, 8'h90);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("zero char", q[7:0], 8'h00);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("after break", q[7:0], d);
      f = 8'($urandom);
      rx(d, 1'b0, 1'b0);
      rx(e, 1'b1, 1'b0);
      rx(f, 1'b0, 1'b0);
      ls("head clean", 8'h84, 8'h80);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      ls("head errored", 8'h84, 8'h84);
      repeat (2) apb(1'b0, ADDR_RX_DATA, 32'h0);
      apb(1'b0, ADDR_LINE_STAT, 32'h0);
      ls("summary off", 8'h80, 8'h00);
      for (int i = 0; i < 17; i++) begin
         d = 8'($urandom);
         if (i < 16) buf_q[i] = d;
         rx(d, 1'b0, 1'b0);
      end
      ls("fifo overrun", 8'h03, 8'h03);
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, ADDR_RX_DATA, 32'h0);
         chk("fifo data", q[7:0], buf_q[i]);
      end
      ls("fifo empty", 8'h01, 8'h00);
      apb(1'b1, ADDR_CTRL, 32'h6);
      apb(1'b1, ADDR_TX_DATA, {24'h0, d});
      repeat (4) @(posedge clk);
      apb(1'b1, ADDR_TX_DATA, {24'h0, e});
      ls("tx loaded", 8'h60, 8'h00);
      repeat (200) @(posedge clk);
      ls("tx moved", 8'h60, 8'h20);
      repeat (250) @(posedge clk);
      ls("tx idle", 8'h60, 8'h60);
      apb(1'b1, ADDR_CTRL, 32'h7);
      apb(1'b1, ADDR_IRQ_EN, 32'h2);
      repeat (3) apb(1'b1, ADDR_TX_DATA, {24'h0, f});
      ls("fifo tx", 8'h60, 8'h00);
      repeat (700) @(posedge clk);
      ls("fifo tx idle", 8'h60, 8'h60);
      chk("holding_reg_empty irq", irq, 1'b1);
      apb(1'b1, ADDR_IRQ_EN, 32'h0);
      repeat (3) @(posedge clk);
      chk("masked", irq, 1'b0);
      close_out();
   end
endmodule : test_uls_line_status
bind uls_top uls_top_chk uls_top_chk_inst (.clk(clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serial_rx_input(serial_rx_input),
   .serial_tx_output(serial_tx_output), .irq(irq));
